// File: rtl/uefc_top.sv
// Functional notes
// (R1) direction control off: transmit interrupt when holding register empties
// (R2) direction control on: line released one bit time after last stop bit
// (R3) direction control on: transmit interrupt waits for empty shift register
// (R4) direction control on: direction returns to transmit on each FIFO write
// (R5) inversion bit flips the direction output polarity
// (R6) two-bit field selects trigger table A to D
// (R7) swap off: scratch location is plain read/write storage
// (R8) swap on: reads give FIFO count, writes go to mode select
// (R9) trigger select bit routes trigger and count to receiver or transmitter
// (R10) bits 3:2 choose transmit flow characters: none, first, second, both
// (R11) both pairs: each code is first character then second character
// (R12) bits 1:0 choose receive comparison: none, first pair, second pair
// (R13) 11 with single transmit pair: either character matches
// (R14) 11 with both or no transmit pairs: sequence first-then-second matches
// (R15) software clears flow select bits before setting new ones
// (R16) enhanced bits writable only while enhanced enable is one
// (R17) enhanced bits clear to zero on reset
// (R18) special detect: second pause character stored, status bit 4 set
// (R19) special detect with first-pair comparison: both work independently
// (R20) special detect with second pair: character dropped, pause and special raised; code sets the special flag only with interrupt enable bit 5 set
// (R21) auto request: interrupt at trigger, request high at upper level
// (R22) auto request: request low again below lower level
// (R23) auto request acts only after host asserts request bit
// (R24) no hardware flow control: request pin follows modem control bit
// (R25) auto clear-to-send: transmission halts while input is high
// (R26) direction low while sending, high while receiving, swapped when inverted
// (R27) hysteresis fields set distance; zero uses the next trigger levels
// (R28) character in shift register finishes before a halt
// (R29) pause code suspends transmit, resume restarts, codes not stored
`timescale 1ns/1ns
module uefc_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire uefc_pkg::uefc_core_in_t core_in,
  output uefc_pkg::uefc_core_out_t core_out,
  input wire logic cts_n,
  output logic rts_n
);
  import uefc_pkg::*;

  uefc_regs_t r, next_r;
  uefc_core_out_t o, next_o;
  uefc_dir_t dir, next_dir;
  uefc_fs_t fs, next_fs;
  logic aw_free, next_aw_free, w_free, next_w_free;
  logic [7:0] wa, next_wa, wd, next_wd;
  logic next_bvalid, next_rvalid, next_arready;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic cts_m, cts_s;
  logic paused, next_paused, seq_p, next_seq_p, seq_r, next_seq_r;
  logic send_two, next_send_two, pend_p, next_pend_p;
  logic auto_hi, next_auto_hi, next_rts_n;
  logic [1:0] rxm, txm;
  logic m_p1, m_p2, m_r1, m_r2, single, seq, spec_on;
  logic pause_ev, resume_ev, spec_ev, drop, arts_on;
  logic [5:0] hyst;
  logic [7:0] up8, lo8, rd;
  logic [6:0] cnt;
  logic rd_hit, do_wr;

  function automatic logic [7:0] gate8(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] m, input logic en);
    gate8 = en ? nw : ((old & m) | (nw & ~m));
  endfunction : gate8

  // ==================================================
  // clear-to-send synchroniser
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_m <= 1'b1;
      cts_s <= 1'b1;
    end else begin
      cts_m <= cts_n;
      cts_s <= cts_m;
    end
  end

  // ==================================================
  // receive matching and flow control
  always_comb begin
    rxm = r.enh[1:0];
    txm = r.enh[3:2];
    spec_on = r.enh[EF_SPEC];
    m_p1 = core_in.rx_data == r.ps1;
    m_p2 = core_in.rx_data == r.ps2;
    m_r1 = core_in.rx_data == r.rs1;
    m_r2 = core_in.rx_data == r.rs2;
    // (R12) (R13) single-character comparison
    single = (rxm == SW_FIRST) || (rxm == SW_SECOND) ||
             (rxm == SW_BOTH && (txm == SW_FIRST || txm == SW_SECOND));
    // (R14) (R11) two-character sequence mode
    seq = (rxm == SW_BOTH) && !single;
    pause_ev = core_in.rx_valid && (single ? ((rxm[SW_B1] && m_p1) || (rxm[SW_B2] && m_p2))
                                           : (seq && seq_p && m_p2));
    resume_ev = core_in.rx_valid && (single ? ((rxm[SW_B1] && m_r1) || (rxm[SW_B2] && m_r2))
                                            : (seq && seq_r && m_r2));
    next_seq_p = core_in.rx_valid ? (seq && m_p1) : seq_p;
    next_seq_r = core_in.rx_valid ? (seq && m_r1) : seq_r;
    // (R18) (R19) (R20) special character, flag gated by enable only in second-pair comparison mode
    spec_ev = core_in.rx_valid && spec_on && m_p2 && (rxm != SW_SECOND || r.interrupt_enable_reg[IE_SPEC]);
    // (R29) flow codes are not stored; a lone first character of a pair is lost
    drop = pause_ev || resume_ev || (seq && (m_p1 || m_r1));
    // (R29) pause and resume of the transmitter
    if (rxm == SW_NONE) next_paused = 1'b0;
    else if (pause_ev) next_paused = 1'b1;
    else if (resume_ev) next_paused = 1'b0;
    else next_paused = paused;
    // (R10) (R11) outgoing flow characters, first then second in both-pair mode
    next_fs = fs;
    next_send_two = send_two;
    next_pend_p = pend_p;
    case (fs)
      FS_IDLE: begin
        if ((core_in.send_pause || core_in.send_resume) && txm != SW_NONE) begin
          next_fs = FS_ONE;
          next_pend_p = core_in.send_pause;
          next_send_two = txm == SW_BOTH;
        end
      end
      FS_ONE: begin
        if (core_in.flow_ready) next_fs = send_two ? FS_TWO : FS_IDLE;
      end
      FS_TWO: begin
        if (core_in.flow_ready) next_fs = FS_IDLE;
      end
      default: next_fs = FS_IDLE;
    endcase
    // (R2) (R4) half-duplex direction sequence
    next_dir = dir;
    case (dir)
      DIR_RX: begin
        if (core_in.tx_push) next_dir = DIR_TX;
      end
      DIR_TX: begin
        if (core_in.char_done && core_in.fifo_empty && !core_in.tx_push) next_dir = DIR_WAIT;
      end
      DIR_WAIT: begin
        if (core_in.tx_push) next_dir = DIR_TX;
        else if (core_in.bit_tick) next_dir = DIR_RX;
      end
      default: next_dir = DIR_RX;
    endcase
    if (!r.feat[FT_DIR]) next_dir = DIR_RX;
    // (R27) hysteresis, zero means the core's next trigger levels
    hyst = HYST[{r.enhanced_mode_select[5:4], r.feat[1:0]}];
    up8 = (hyst == 6'h00) ? {1'b0, core_in.rx_up} : 8'({1'b0, core_in.rx_trig} + {2'b00, hyst});
    lo8 = (hyst == 6'h00) ? {1'b0, core_in.rx_lo} :
          ((core_in.rx_trig > 7'(hyst)) ? {1'b0, core_in.rx_trig - 7'(hyst)} : RST_ZERO);
    // (R23) automatic request only once the host has asserted it
    arts_on = r.enh[EF_ARTS] && r.modem_control_reg[MC_RTS];
    // (R21) (R22) request high at upper level, low below lower level
    if (!arts_on) next_auto_hi = 1'b0;
    else if ({1'b0, core_in.rx_count} >= up8) next_auto_hi = 1'b1;
    else if ({1'b0, core_in.rx_count} < lo8) next_auto_hi = 1'b0;
    else next_auto_hi = auto_hi;
    // (R5) (R26) direction pin polarity
    if (r.feat[FT_DIR]) next_rts_n = (next_dir == DIR_RX) ? !r.enhanced_mode_select[EM_INV] : r.enhanced_mode_select[EM_INV];
    else if (arts_on) next_rts_n = next_auto_hi;
    // (R24) plain output, modem bit one drives the pin low
    else next_rts_n = !r.modem_control_reg[MC_RTS];
    // ==== core outputs
    next_o = o;
    // (R1) (R3) transmit interrupt source
    next_o.tx_int = r.feat[FT_DIR] ? (core_in.fifo_empty && core_in.shift_empty)
                                   : core_in.hold_empty;
    // (R25) (R28) the core only samples this before starting a new character
    next_o.tx_go = !next_paused && !(r.enh[EF_ACTS] && cts_s);
    next_o.rx_store = core_in.rx_valid && !drop;
    next_o.rx_char = core_in.rx_data;
    // (R21) receive trigger interrupt under auto request
    next_o.lvl_int = arts_on && (core_in.rx_count >= core_in.rx_trig);
    next_o.flow_valid = next_fs != FS_IDLE;
    if (next_fs == FS_TWO || (next_fs == FS_ONE && txm == SW_SECOND))
      next_o.flow_char = next_pend_p ? r.ps2 : r.rs2;
    else
      next_o.flow_char = next_pend_p ? r.ps1 : r.rs1;
    // (R6) trigger table select
    next_o.table_sel = next_r.feat[5:4];
    next_o.trg_rx = next_r.trg_rx;
    next_o.trg_tx = next_r.trg_tx;
    next_o.interrupt_enable_reg = next_r.interrupt_enable_reg;
    next_o.fifo_control_reg = next_r.fifo_control_reg;
    next_o.modem_control_reg = next_r.modem_control_reg;
  end

  // ==================================================
  // bus slave and registers
  always_comb begin
    next_r = r;
    next_aw_free = aw_free;
    next_w_free = w_free;
    next_wa = wa;
    next_wd = wd;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_arready = arready;
    // (R9) count routed by trigger select, (R8) mode set by mode select
    if (r.feat[FT_SWAP]) begin
      if (!r.enhanced_mode_select[0]) cnt = core_in.rx_count;
      else if (r.enhanced_mode_select[1:0] == CNT_TX) cnt = core_in.tx_count;
      else cnt = r.alt_tx ? core_in.tx_count : core_in.rx_count;
    end else begin
      cnt = r.feat[FT_TSEL] ? core_in.tx_count : core_in.rx_count;
    end
    if (aw_free && awvalid) begin
      next_aw_free = 1'b0;
      next_wa = awaddr;
    end
    if (w_free && wvalid) begin
      next_w_free = 1'b0;
      next_wd = wstrb[0] ? wdata[7:0] : RST_ZERO;
    end
    do_wr = !aw_free && !w_free && !bvalid;
    if (do_wr) begin
      next_aw_free = 1'b1;
      next_w_free = 1'b1;
      next_bvalid = 1'b1;
      next_bresp = RESP_OK;
      case (wa)
        OFF_FEAT: next_r.feat = wd;
        OFF_ENH: next_r.enh = wd;
        OFF_ENHANCED_MODE_SELECT, OFF_SCR: begin
          // (R7) (R8) swapped writes land in mode select
          if (r.feat[FT_SWAP] || wa == OFF_ENHANCED_MODE_SELECT) begin
            next_r.enhanced_mode_select = wd;
            next_r.alt_tx = 1'b0;
          end else begin
            next_r.scr = wd;
          end
        end
        // (R9) trigger write routed by select bit
        OFF_TRG: begin
          if (r.feat[FT_TSEL]) next_r.trg_tx = wd;
          else next_r.trg_rx = wd;
        end
        // (R16) enhanced bits locked while enable is zero
        OFF_IER: next_r.interrupt_enable_reg = gate8(r.interrupt_enable_reg, wd, ENH_IER, r.enh[EF_EN]);
        OFF_ISR: next_r.interrupt_status_reg = r.enh[EF_EN] ? (wd & ENH_ISR) : r.interrupt_status_reg;
        OFF_FCR: next_r.fifo_control_reg = gate8(r.fifo_control_reg, wd, ENH_FCR, r.enh[EF_EN]);
        OFF_MCR: next_r.modem_control_reg = gate8(r.modem_control_reg, wd, ENH_MCR, r.enh[EF_EN]);
        OFF_RS1: next_r.rs1 = wd;
        OFF_RS2: next_r.rs2 = wd;
        OFF_PS1: next_r.ps1 = wd;
        OFF_PS2: next_r.ps2 = wd;
        OFF_FCNT, OFF_STAT: next_bresp = RESP_OK;
        default: next_bresp = RESP_ERR;
      endcase
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    // status events win over a clear in the same cycle
    if (spec_ev) next_r.interrupt_status_reg[IS_SPEC] = 1'b1;
    if (pause_ev) next_r.interrupt_status_reg[IS_PAUSE] = 1'b1;
    rd_hit = 1'b1;
    case (araddr)
      OFF_FEAT: rd = r.feat;
      OFF_ENH: rd = r.enh;
      OFF_ENHANCED_MODE_SELECT: rd = r.enhanced_mode_select;
      // (R7) (R8) swapped reads return the count
      OFF_SCR: rd = r.feat[FT_SWAP] ? {1'b0, cnt} : r.scr;
      OFF_TRG: rd = RST_ZERO;
      OFF_FCNT: rd = r.feat[FT_TSEL] ? {1'b0, core_in.tx_count} : {1'b0, core_in.rx_count};
      OFF_IER: rd = r.interrupt_enable_reg;
      OFF_ISR: rd = r.interrupt_status_reg;
      OFF_FCR: rd = r.fifo_control_reg;
      OFF_MCR: rd = r.modem_control_reg;
      OFF_RS1: rd = r.rs1;
      OFF_RS2: rd = r.rs2;
      OFF_PS1: rd = r.ps1;
      OFF_PS2: rd = r.ps2;
      OFF_STAT: rd = {4'h0, auto_hi, paused, dir != DIR_RX, o.tx_int};
      default: begin
        rd = RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
    if (arready && arvalid) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = {RD_PAD, rd};
      next_rresp = rd_hit ? RESP_OK : RESP_ERR;
      // alternate count mode steps rx, tx, rx, ...
      if (araddr == OFF_SCR && r.feat[FT_SWAP] && r.enhanced_mode_select[1:0] == CNT_ALT) next_r.alt_tx = !r.alt_tx;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // ==================================================
  // state registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // (R17) enhanced bits and flow settings clear on reset
      r <= '{feat: RST_ZERO, enh: RST_ZERO, enhanced_mode_select: RST_ENHANCED_MODE_SELECT, scr: RST_SCR, trg_rx: RST_ZERO,
             trg_tx: RST_ZERO, interrupt_enable_reg: RST_ZERO, interrupt_status_reg: RST_ZERO, fifo_control_reg: RST_ZERO, modem_control_reg: RST_ZERO,
             rs1: RST_ZERO, rs2: RST_ZERO, ps1: RST_ZERO, ps2: RST_ZERO, alt_tx: 1'b0};
      o <= '0;
      dir <= DIR_RX;
      fs <= FS_IDLE;
      aw_free <= 1'b1;
      w_free <= 1'b1;
      wa <= RST_ZERO;
      wd <= RST_ZERO;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
      rvalid <= 1'b0;
      rresp <= RESP_OK;
      rdata <= '0;
      arready <= 1'b1;
      paused <= 1'b0;
      seq_p <= 1'b0;
      seq_r <= 1'b0;
      send_two <= 1'b0;
      pend_p <= 1'b0;
      auto_hi <= 1'b0;
      rts_n <= 1'b1;
    end else begin
      r <= next_r;
      o <= next_o;
      dir <= next_dir;
      fs <= next_fs;
      aw_free <= next_aw_free;
      w_free <= next_w_free;
      wa <= next_wa;
      wd <= next_wd;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      arready <= next_arready;
      paused <= next_paused;
      seq_p <= next_seq_p;
      seq_r <= next_seq_r;
      send_two <= next_send_two;
      pend_p <= next_pend_p;
      auto_hi <= next_auto_hi;
      rts_n <= next_rts_n;
    end
  end

  assign awready = aw_free;
  assign wready = w_free;
  assign core_out = o;

  // ==================================================
  // assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_TXI_STD: assert property (!r.feat[FT_DIR] && core_in.hold_empty |=> o.tx_int) // (R1)
    else $error("tx interrupt missing with holding register empty");
  AST_TXI_DIR: assert property (r.feat[FT_DIR] && !core_in.shift_empty |=> !o.tx_int) // (R3)
    else $error("tx interrupt raised before shift register empty");
  AST_DIR_TX: assert property (r.feat[FT_DIR] && core_in.tx_push |=> dir == DIR_TX) // (R4)
    else $error("direction not back to transmit on fifo write");
  AST_DIR_REL: assert property (dir == DIR_WAIT && r.feat[FT_DIR] && core_in.bit_tick &&
    !core_in.tx_push |=> dir == DIR_RX ##0 rts_n == !$past(r.enhanced_mode_select[EM_INV])) // (R2)
    else $error("direction not released one bit time after last stop");
  AST_POL: assert property (r.feat[FT_DIR] && next_dir == DIR_TX |=> rts_n == $past(r.enhanced_mode_select[EM_INV])) // (R26)
    else $error("direction pin polarity wrong while sending");
  AST_GPIO: assert property (!r.feat[FT_DIR] && !arts_on |=> rts_n == !$past(r.modem_control_reg[MC_RTS])) // (R24)
    else $error("request pin does not follow modem bit");
  AST_CTS: assert property (r.enh[EF_ACTS] && cts_s |=> !o.tx_go) // (R25)
    else $error("transmit allowed while clear-to-send high");
  AST_LOCK: assert property (!r.enh[EF_EN] |=> (r.interrupt_enable_reg & ENH_IER) == ($past(r.interrupt_enable_reg) & ENH_IER)) // (R16)
    else $error("enhanced interrupt enable bits changed while locked");
  AST_SPEC2: assert property (core_in.rx_valid && spec_on && rxm == SW_SECOND && m_p2
    |=> !o.rx_store ##0 r.interrupt_status_reg[IS_PAUSE]) // (R20)
    else $error("second pause char stored or pause not flagged");
  AST_PAUSE: assert property (pause_ev && rxm != SW_NONE |=> !o.tx_go ##1 (paused || $past(resume_ev))) // (R29)
    else $error("pause code did not stop transmit");
endmodule : uefc_top

// File: rtl/uefc_pkg.sv
package uefc_pkg;
  // ==================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_ENH = 8'h04;
  localparam logic [7:0] OFF_ENHANCED_MODE_SELECT = 8'h08;
  localparam logic [7:0] OFF_SCR = 8'h0C;
  localparam logic [7:0] OFF_TRG = 8'h10;
  localparam logic [7:0] OFF_FCNT = 8'h14;
  localparam logic [7:0] OFF_IER = 8'h18;
  localparam logic [7:0] OFF_ISR = 8'h1C;
  localparam logic [7:0] OFF_FCR = 8'h20;
  localparam logic [7:0] OFF_MCR = 8'h24;
  localparam logic [7:0] OFF_RS1 = 8'h28;
  localparam logic [7:0] OFF_RS2 = 8'h2C;
  localparam logic [7:0] OFF_PS1 = 8'h30;
  localparam logic [7:0] OFF_PS2 = 8'h34;
  localparam logic [7:0] OFF_STAT = 8'h38;
  // ==================================================
  // reset values, masks, bus answers
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SCR = 8'hFF;
  localparam logic [7:0] RST_ENHANCED_MODE_SELECT = 8'h80;
  localparam logic [7:0] ENH_IER = 8'hF0;
  localparam logic [7:0] ENH_ISR = 8'h30;
  localparam logic [7:0] ENH_FCR = 8'h30;
  localparam logic [7:0] ENH_MCR = 8'hE0;
  localparam logic [23:0] RD_PAD = 24'h00_0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ==================================================
  // bit positions
  localparam int FT_DIR = 3;
  localparam int FT_SWAP = 6;
  localparam int FT_TSEL = 7;
  localparam int EF_EN = 4;
  localparam int EF_SPEC = 5;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;
  localparam int EM_INV = 3;
  localparam int MC_RTS = 1;
  localparam int IE_SPEC = 5;
  localparam int IS_SPEC = 4;
  localparam int IS_PAUSE = 5;
  localparam int SW_B1 = 1;
  localparam int SW_B2 = 0;
  // ==================================================
  // mode codes
  localparam logic [1:0] SW_NONE = 2'h0;
  localparam logic [1:0] SW_FIRST = 2'h2;
  localparam logic [1:0] SW_SECOND = 2'h1;
  localparam logic [1:0] SW_BOTH = 2'h3;
  localparam logic [1:0] CNT_TX = 2'h1;
  localparam logic [1:0] CNT_ALT = 2'h3;
  localparam logic [5:0] HYST [0:15] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
  // ==================================================
  // types
  typedef enum logic [2:0] {DIR_RX = 3'h1, DIR_TX = 3'h2, DIR_WAIT = 3'h4} uefc_dir_t;
  typedef enum logic [2:0] {FS_IDLE = 3'h1, FS_ONE = 3'h2, FS_TWO = 3'h4} uefc_fs_t;
  typedef struct packed {
    logic [7:0] feat, enh, enhanced_mode_select, scr, trg_rx, trg_tx, interrupt_enable_reg, interrupt_status_reg, fifo_control_reg, modem_control_reg, rs1, rs2, ps1, ps2;
    logic alt_tx;
  } uefc_regs_t;
  typedef struct packed {
    logic tx_push, hold_empty, fifo_empty, shift_empty, char_done, bit_tick, rx_valid;
    logic [7:0] rx_data;
    logic [6:0] rx_count, tx_count, rx_trig, rx_up, rx_lo;
    logic send_pause, send_resume, flow_ready;
  } uefc_core_in_t;
  typedef struct packed {
    logic tx_int, tx_go, rx_store;
    logic [7:0] rx_char;
    logic lvl_int, flow_valid;
    logic [7:0] flow_char;
    logic [1:0] table_sel;
    logic [7:0] trg_rx, trg_tx, interrupt_enable_reg, fifo_control_reg, modem_control_reg;
  } uefc_core_out_t;
endpackage : uefc_pkg

// File: tb/uefc_far.sv
`timescale 1ns/1ns
// ==================================================
// remote serial device: holds off the sender, takes flow codes slowly
module uefc_far (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hold_off,
  input wire logic flow_valid,
  input wire logic [7:0] flow_char,
  output logic cts_n,
  output logic flow_ready,
  output logic [7:0] last_flow
);
  logic [1:0] cnt;
  assign cts_n = hold_off;
  // codes accepted one at a time, in order
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 2'h0;
      flow_ready <= 1'b0;
      last_flow <= 8'h00;
    end else begin
      flow_ready <= flow_valid && cnt == 2'h1 && !flow_ready;
      cnt <= flow_valid ? cnt + 2'h1 : 2'h0;
      if (flow_valid && flow_ready) last_flow <= flow_char;
    end
  end
endmodule : uefc_far

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import uefc_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, cts_n, rts_n, hold_off = 1'b0;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [7:0] v, last_flow;
  logic flow_ready;
  uefc_core_in_t ci;
  uefc_core_out_t core_out;
  int n_fail = 0, n_compared = 0;
  uefc_core_in_t ci_q;
  always_comb begin
    ci_q = ci;
    ci_q.flow_ready = flow_ready;
  end
  uefc_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .core_in(ci_q), .core_out(core_out), .cts_n(cts_n),
    .rts_n(rts_n));
  uefc_far far (.sys_clk(sys_clk), .reset_n(reset_n), .hold_off(hold_off), .flow_valid(core_out.flow_valid),
    .flow_char(core_out.flow_char), .cts_n(cts_n), .flow_ready(flow_ready), .last_flow(last_flow));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // ==================================================
  // bus tasks
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : chk
  // one received character, valid for a single sampled edge
  task automatic rx(input logic [7:0] c);
    ci.rx_data <= c;
    ci.rx_valid <= 1'b1;
    @(posedge sys_clk);
    ci.rx_valid <= 1'b0;
    #1;
  endtask : rx
  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task automatic print_verdict;
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // ==================================================
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #500000;
    n_fail++;
    print_verdict();
  end
  // ==================================================
  // tests
  initial begin
    ci = '0;
    ci.hold_empty = 1'b1;
    ci.fifo_empty = 1'b1;
    ci.shift_empty = 1'b1;
    ci.rx_count = 7'h15;
    ci.tx_count = 7'h03;
    ci.rx_trig = 7'h10;
    ci.rx_up = 7'h14;
    ci.rx_lo = 7'h08;
    step(6);
    reset_n <= 1'b1;
    step(1);
    rd(OFF_IER, v);
    chk(v, 8'h00);
    rd(OFF_ENHANCED_MODE_SELECT, v);
    chk(v, 8'h80);
    rd(OFF_SCR, v);
    chk(v, 8'hff);
    wr(OFF_SCR, 8'h5a);
    rd(OFF_SCR, v);
    chk(v, 8'h5a);
    wr(OFF_IER, 8'hff);
    rd(OFF_IER, v);
    chk(v, 8'h0f);
    wr(OFF_ENH, 8'h10);
    wr(OFF_IER, 8'hff);
    rd(OFF_IER, v);
    chk(v, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FEAT, 8'(i << 4));
      step(1);
      chk({6'h00, core_out.table_sel}, 8'(i));
    end
    wr(OFF_FEAT, 8'h40);
    wr(OFF_SCR, 8'h08);
    rd(OFF_ENHANCED_MODE_SELECT, v);
    chk(v, 8'h08);
    rd(OFF_SCR, v);
    chk(v, 8'h15);
    wr(OFF_FEAT, 8'h80);
    wr(OFF_TRG, 8'h22);
    rd(OFF_FCNT, v);
    chk(v, 8'h03);
    chk(core_out.trg_tx, 8'h22);
    wr(OFF_FEAT, 8'h00);
    rd(OFF_SCR, v);
    chk(v, 8'h5a);
    rd(8'h3c, v);
    chk({6'h00, resp}, {6'h00, RESP_ERR});
    wr(OFF_MCR, 8'h02);
    step(2);
    chk({7'h00, rts_n}, 8'h00);
    wr(OFF_MCR, 8'h00);
    step(2);
    chk({7'h00, rts_n}, 8'h01);
    wr(OFF_ENH, 8'h30);
    wr(OFF_PS2, 8'h13);
    rx(8'h13);
    chk({7'h00, core_out.rx_store}, 8'h01);
    chk(core_out.rx_char, 8'h13);
    rd(OFF_ISR, v);
    chk(v & 8'h10, 8'h10);
    // mode select still holds the inversion bit from the swap test
    ci.shift_empty <= 1'b0;
    wr(OFF_FEAT, 8'h08);
    step(2);
    chk({7'h00, rts_n}, 8'h00);
    chk({7'h00, core_out.tx_int}, 8'h00);
    ci.tx_push <= 1'b1;
    step(1);
    ci.tx_push <= 1'b0;
    step(1);
    chk({7'h00, rts_n}, 8'h01);
    ci.char_done <= 1'b1;
    step(1);
    ci.char_done <= 1'b0;
    step(2);
    chk({7'h00, rts_n}, 8'h01);
    ci.bit_tick <= 1'b1;
    step(1);
    ci.bit_tick <= 1'b0;
    step(1);
    chk({7'h00, rts_n}, 8'h00);
    wr(OFF_ENHANCED_MODE_SELECT, 8'h00);
    step(2);
    chk({7'h00, rts_n}, 8'h01);
    ci.tx_push <= 1'b1;
    step(1);
    ci.tx_push <= 1'b0;
    step(1);
    chk({7'h00, rts_n}, 8'h00);
    wr(OFF_FEAT, 8'h00);
    wr(OFF_ENH, 8'h00);
    wr(OFF_ENH, 8'h80);
    chk({7'h00, core_out.tx_int}, 8'h01);
    hold_off <= 1'b1;
    step(5);
    chk({7'h00, core_out.tx_go}, 8'h00);
    hold_off <= 1'b0;
    step(5);
    chk({7'h00, core_out.tx_go}, 8'h01);
    // flow select cleared before a new setting
    wr(OFF_ENH, 8'h00);
    wr(OFF_PS1, 8'h93);
    wr(OFF_ENH, 8'h08);
    ci.send_pause <= 1'b1;
    step(1);
    ci.send_pause <= 1'b0;
    step(10);
    chk(last_flow, 8'h93);
    // cleared again before second-pair comparison with special detect
    wr(OFF_ENH, 8'h00);
    wr(OFF_ENH, 8'h21);
    wr(OFF_RS2, 8'h11);
    rx(8'h13);
    chk({7'h00, core_out.rx_store}, 8'h00);
    chk({7'h00, core_out.tx_go}, 8'h00);
    rd(OFF_ISR, v);
    chk(v & 8'h20, 8'h20);
    rx(8'h11);
    chk({7'h00, core_out.rx_store}, 8'h00);
    chk({7'h00, core_out.tx_go}, 8'h01);
    wr(OFF_ENH, 8'h00);
    // host asserts the request before automatic control
    wr(OFF_MCR, 8'h02);
    wr(OFF_ENH, 8'h40);
    step(2);
    chk({7'h00, rts_n}, 8'h01);
    chk({7'h00, core_out.lvl_int}, 8'h01);
    ci.rx_count <= 7'h07;
    step(2);
    chk({7'h00, rts_n}, 8'h00);
    print_verdict();
  end
endmodule : testbench
